/* File: core/ccs_defines.svh */
// register offsets, bit positions, reset values and timing counts of the clock select block
`ifndef CCS_DEFINES_SVH
`define CCS_DEFINES_SVH

// ==========================================================
// register map
`define CCS_OFF_CLKS 8'h00
`define CCS_OFF_STAT 8'h01

// ==========================================================
// clock select register fields
`define CCS_BIT_PLL_SEL 7
`define CCS_BIT_PSTOP 6
`define CCS_BIT_WD_ACLK_DIS 5
`define CCS_BIT_WD_SRC_HIGH 4
`define CCS_BIT_TICK_PSR 3
`define CCS_BIT_WD_PSR 2
`define CCS_BIT_TICK_SEL 1
`define CCS_BIT_WD_SRC_LOW 0
`define CCS_CLKS_RESET 8'h80

// ==========================================================
// status register fields
`define CCS_STAT_OSC_Q 0
`define CCS_STAT_WD_ONCE 1
`define CCS_STAT_RESET_OK 2
`define CCS_STAT_IN_STOP 3

// ==========================================================
// timing
`define CCS_BUS_DIV 2
`define CCS_ACLK_LAT_MAX 4
`define CCS_ACLK_SYNC 2

`endif

/* File: core/ccs_pkg.sv */
// types of the clock select block
package ccs_pkg;

  // ========================================================
  // watchdog clock source
  typedef enum logic [1:0] {
    CCS_WD_IRC = 2'b00,
    CCS_WD_OSC = 2'b01,
    CCS_WD_ACLK = 2'b10
  } ccs_wd_src_e;

  // ========================================================
  // register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ccs_bus_s;

  // ========================================================
  // block state
  typedef struct packed {
    logic [7:0] clks;
    logic wd_once;
    logic low_reset_ok;
    logic stop_d;
    logic [1:0] aclk_pipe;
    logic wd_restart;
    logic tick_restart;
    logic [7:0] rdata;
  } ccs_state_s;

endpackage

/* File: core/ccs_ctrl.sv */
// clock source select and stop-mode clock gating control
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ps
`include "ccs_defines.svh"

// How it works
// - write lock set: all writes ignored
// - special mode, unlocked: every bit writable
// - normal mode: pll, pstop, run bits, tick writable
// - normal: watchdog bits frozen after watchdog write
// - low select cleared by osc loss: settable again
// - high select free, never cleared by hardware
// - pll select cleared only when qualified, forced on loss
// - full stop entry forces pll select
// - system clock from pll or osc, bus halved; code only drives sys_clk_from_pll, no bus divider
// - pstop bit keeps oscillator in stop
// - aclk disable gates watchdog aclk in stop
// - aclk gate synchronised, at most four aclk cycles
// - wakeup timer aclk never gated
// - high select: aclk, low changes ignored
// - high select change restarts watchdog
// - tick runs in pseudo stop if both set and tick select on osc
// - watchdog runs in pseudo stop if both set and osc source selected
// - tick select needs qualification, change restarts
// - low select needs qualification, change restarts watchdog unless high select set
module ccs_ctrl import ccs_pkg::*; #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // chip status
  input wire logic write_lock_flag,
  input wire logic special_mode,
  input wire logic watchdog_ctrl_write,
  input wire logic osc_qualified,
  input wire logic stop_mode,
  input wire logic aclk_tick,
  // clock selection
  output logic sys_clk_from_pll,
  output logic osc_run_in_stop,
  output ccs_wd_src_e watchdog_src,
  output logic watchdog_restart,
  output logic watchdog_clk_run,
  output logic watchdog_aclk_en,
  output logic tick_from_osc,
  output logic tick_restart,
  output logic tick_clk_run,
  output logic wakeup_aclk_en
);

  // ========================================================
  // elaboration checks
  if (ADDR_W < 8) begin : g_bad_addr
    $error("ADDR_W must be at least 8");
  end

  // ========================================================
  // state
  ccs_state_s st;
  ccs_state_s next_st;
  ccs_bus_s bus;
  logic hit_clks;
  logic hit_stat;
  logic wr_ok;
  logic full_stop_entry;
  logic [7:0] wmask;
  logic [7:0] cand;
  logic aclk_gate_req;

  assign bus = {addr[7:0], wdata, wr, rd};
  assign hit_clks = (addr == ADDR_W'(`CCS_OFF_CLKS));
  assign hit_stat = (addr == ADDR_W'(`CCS_OFF_STAT));

  // ========================================================
  // next state
  always_comb begin
    next_st = st;
    wr_ok = bus.wr && hit_clks && !write_lock_flag;
    full_stop_entry = stop_mode && !st.stop_d && !st.clks[`CCS_BIT_PSTOP];
    // bits writable in the current mode
    if (special_mode) begin
      wmask = 8'hff;
    end else begin
      wmask = 8'h00;
      wmask[`CCS_BIT_PLL_SEL] = 1'b1;
      wmask[`CCS_BIT_PSTOP] = 1'b1;
      wmask[`CCS_BIT_TICK_PSR] = 1'b1;
      wmask[`CCS_BIT_WD_PSR] = 1'b1;
      wmask[`CCS_BIT_TICK_SEL] = 1'b1;
      if (!st.wd_once) begin
        wmask[`CCS_BIT_WD_ACLK_DIS] = 1'b1;
        wmask[`CCS_BIT_WD_SRC_HIGH] = 1'b1;
        wmask[`CCS_BIT_WD_SRC_LOW] = 1'b1;
      end else if (st.low_reset_ok && bus.wdata[`CCS_BIT_WD_SRC_LOW]) begin
        wmask[`CCS_BIT_WD_SRC_LOW] = 1'b1;
      end
    end
    cand = (st.clks & ~wmask) | (bus.wdata & wmask);
    if (wr_ok) begin
      if (!osc_qualified) begin
        cand[`CCS_BIT_PLL_SEL] = 1'b1;
        cand[`CCS_BIT_TICK_SEL] = st.clks[`CCS_BIT_TICK_SEL] & cand[`CCS_BIT_TICK_SEL];
        cand[`CCS_BIT_WD_SRC_LOW] = st.clks[`CCS_BIT_WD_SRC_LOW] & cand[`CCS_BIT_WD_SRC_LOW];
      end
      next_st.clks = cand;
      if (cand[`CCS_BIT_WD_SRC_LOW]) begin
        next_st.low_reset_ok = 1'b0;
      end
    end
    // hardware forcing wins over the write
    if (!osc_qualified) begin
      next_st.clks[`CCS_BIT_PLL_SEL] = 1'b1;
      next_st.clks[`CCS_BIT_TICK_SEL] = 1'b0;
      next_st.clks[`CCS_BIT_WD_SRC_LOW] = 1'b0;
      if (st.clks[`CCS_BIT_WD_SRC_LOW]) begin
        next_st.low_reset_ok = 1'b1;
      end
    end
    if (full_stop_entry) begin
      next_st.clks[`CCS_BIT_PLL_SEL] = 1'b1;
    end
    // write-once event of the watchdog control register
    if (watchdog_ctrl_write) begin
      next_st.wd_once = 1'b1;
    end
    next_st.stop_d = stop_mode;
    // restarts of the watchdog and tick periods
    next_st.wd_restart = (next_st.clks[`CCS_BIT_WD_SRC_HIGH] != st.clks[`CCS_BIT_WD_SRC_HIGH])
      || (!next_st.clks[`CCS_BIT_WD_SRC_HIGH] && !st.clks[`CCS_BIT_WD_SRC_HIGH]
      && next_st.clks[`CCS_BIT_WD_SRC_LOW] != st.clks[`CCS_BIT_WD_SRC_LOW]);
    next_st.tick_restart = next_st.clks[`CCS_BIT_TICK_SEL] != st.clks[`CCS_BIT_TICK_SEL];
    // aclk gate crosses over on aclk ticks
    aclk_gate_req = !(stop_mode && st.clks[`CCS_BIT_WD_ACLK_DIS]);
    if (aclk_tick) begin
      next_st.aclk_pipe = {st.aclk_pipe[0], aclk_gate_req};
    end
    // read data
    next_st.rdata = 8'h00;
    if (bus.rd && hit_clks) begin
      next_st.rdata = st.clks;
    end else if (bus.rd && hit_stat) begin
      next_st.rdata[`CCS_STAT_OSC_Q] = osc_qualified;
      next_st.rdata[`CCS_STAT_WD_ONCE] = st.wd_once;
      next_st.rdata[`CCS_STAT_RESET_OK] = st.low_reset_ok;
      next_st.rdata[`CCS_STAT_IN_STOP] = st.stop_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
      st.clks <= `CCS_CLKS_RESET;
      st.aclk_pipe <= 2'b11;
    end else begin
      st <= next_st;
    end
  end

  // ========================================================
  // outputs
  always_comb begin
    rdata = st.rdata;
    sys_clk_from_pll = st.clks[`CCS_BIT_PLL_SEL];
    osc_run_in_stop = st.clks[`CCS_BIT_PSTOP];
    if (st.clks[`CCS_BIT_WD_SRC_HIGH]) begin
      watchdog_src = CCS_WD_ACLK;
    end else if (st.clks[`CCS_BIT_WD_SRC_LOW]) begin
      watchdog_src = CCS_WD_OSC;
    end else begin
      watchdog_src = CCS_WD_IRC;
    end
    watchdog_restart = st.wd_restart;
    tick_from_osc = st.clks[`CCS_BIT_TICK_SEL];
    tick_restart = st.tick_restart;
    watchdog_aclk_en = st.aclk_pipe[1];
    wakeup_aclk_en = 1'b1;
    tick_clk_run = !stop_mode || (st.clks[`CCS_BIT_PSTOP]
      && st.clks[`CCS_BIT_TICK_PSR] && st.clks[`CCS_BIT_TICK_SEL]);
    if (!stop_mode) begin
      watchdog_clk_run = 1'b1;
    end else if (watchdog_src == CCS_WD_ACLK) begin
      watchdog_clk_run = !st.clks[`CCS_BIT_WD_ACLK_DIS];
    end else begin
      watchdog_clk_run = st.clks[`CCS_BIT_PSTOP] && st.clks[`CCS_BIT_WD_PSR]
        && (watchdog_src == CCS_WD_OSC);
    end
  end

  // ========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_lock_blocks_write: assert property (
    (wr && hit_clks && write_lock_flag && osc_qualified && !watchdog_ctrl_write
      && !(stop_mode && !st.stop_d)) |=> $stable(st.clks))
    else $error("write took effect while locked");

  a_special_all_bits: assert property (
    (wr && hit_clks && !write_lock_flag && special_mode && osc_qualified
      && !(stop_mode && !st.stop_d && !st.clks[`CCS_BIT_PSTOP])) |=> st.clks == $past(wdata))
    else $error("special mode write not taken");

  a_normal_free_bits: assert property (
    (wr && hit_clks && !write_lock_flag && !special_mode && osc_qualified && !stop_mode)
      |=> st.clks[`CCS_BIT_PSTOP] == $past(wdata[`CCS_BIT_PSTOP])
      && st.clks[`CCS_BIT_TICK_PSR] == $past(wdata[`CCS_BIT_TICK_PSR]))
    else $error("normal mode free bit not taken");

  a_once_freezes: assert property (
    (st.wd_once && !special_mode) |=>
      $stable(st.clks[`CCS_BIT_WD_ACLK_DIS]) && $stable(st.clks[`CCS_BIT_WD_SRC_HIGH]))
    else $error("frozen watchdog bit changed");

  a_low_reset_again: assert property (
    (wr && hit_clks && !write_lock_flag && st.low_reset_ok && osc_qualified
      && wdata[`CCS_BIT_WD_SRC_LOW]) |=> st.clks[`CCS_BIT_WD_SRC_LOW] && !st.low_reset_ok)
    else $error("low select could not be set again");

  a_high_kept: assert property (
    (!osc_qualified && !(wr && hit_clks)) |=> $stable(st.clks[`CCS_BIT_WD_SRC_HIGH]))
    else $error("high select cleared by hardware");

  a_pll_forced: assert property (
    !osc_qualified |=> sys_clk_from_pll && !tick_from_osc && watchdog_src != CCS_WD_OSC)
    else $error("osc loss did not force selections");

  a_full_stop_pll: assert property (
    (stop_mode && !st.stop_d && !st.clks[`CCS_BIT_PSTOP]) |=> sys_clk_from_pll)
    else $error("full stop did not force pll select");

  a_aclk_latency: assert property (
    (st.clks[`CCS_BIT_WD_ACLK_DIS] && stop_mode && aclk_tick) ##1
      (stop_mode && st.clks[`CCS_BIT_WD_ACLK_DIS] && aclk_tick) [*2]
      |-> ##1 !watchdog_aclk_en)
    else $error("aclk gate later than allowed");

  a_wakeup_free: assert property (
    wakeup_aclk_en)
    else $error("wakeup timer aclk gated");

  a_high_restart: assert property (
    $changed(st.clks[`CCS_BIT_WD_SRC_HIGH]) |-> watchdog_restart)
    else $error("high select change did not restart");

  a_low_no_restart: assert property (
    (st.clks[`CCS_BIT_WD_SRC_HIGH] && $past(st.clks[`CCS_BIT_WD_SRC_HIGH])
      && $changed(st.clks[`CCS_BIT_WD_SRC_LOW])) |-> !watchdog_restart)
    else $error("low change restarted under high select");

  a_tick_stop_run: assert property (
    (stop_mode && !st.clks[`CCS_BIT_TICK_PSR]) |-> !tick_clk_run)
    else $error("tick ran in stop without run bit");

  a_wd_stop_run: assert property (
    (stop_mode && watchdog_src == CCS_WD_IRC) |-> !watchdog_clk_run)
    else $error("watchdog ran in stop on internal rc");

  a_read_back: assert property (
    (rd && hit_clks) |=> rdata == $past(st.clks))
    else $error("read back mismatch");

  a_pll_clear_refused: assert property (
    (wr && hit_clks && !write_lock_flag && !osc_qualified) |=> sys_clk_from_pll)
    else $error("pll select cleared without qualification");

  a_tick_set_refused: assert property (
    (!osc_qualified && !tick_from_osc) |=> !tick_from_osc)
    else $error("tick select set without qualification");

  a_tick_restart: assert property (
    $changed(tick_from_osc) |-> tick_restart)
    else $error("tick select change did not restart");

  a_tick_restart_cause: assert property (
    tick_restart |-> $changed(tick_from_osc))
    else $error("tick restart without select change");

  a_low_restart: assert property (
    ($changed(st.clks[`CCS_BIT_WD_SRC_LOW]) && !st.clks[`CCS_BIT_WD_SRC_HIGH]
      && !$past(st.clks[`CCS_BIT_WD_SRC_HIGH])) |-> watchdog_restart)
    else $error("low select change did not restart");

  a_restart_cause: assert property (
    watchdog_restart |-> ($changed(st.clks[`CCS_BIT_WD_SRC_HIGH])
      || $changed(st.clks[`CCS_BIT_WD_SRC_LOW])))
    else $error("watchdog restart without source change");

  a_pstop_write: assert property (
    (wr && hit_clks && !write_lock_flag)
      |=> osc_run_in_stop == $past(wdata[`CCS_BIT_PSTOP]))
    else $error("pseudo stop select not taken");

  a_aclk_open: assert property (
    ((!stop_mode && aclk_tick) ##1 (!stop_mode && aclk_tick))
      |=> watchdog_aclk_en)
    else $error("watchdog aclk not reopened");

  a_aclk_needs_tick: assert property (
    !aclk_tick |=> $stable(watchdog_aclk_en))
    else $error("aclk gate moved without aclk edge");

  a_wd_aclk_stop: assert property (
    (stop_mode && watchdog_src == CCS_WD_ACLK && st.clks[`CCS_BIT_WD_ACLK_DIS])
      |-> !watchdog_clk_run)
    else $error("watchdog ran on gated aclk in stop");

  a_run_awake: assert property (
    !stop_mode |-> tick_clk_run && watchdog_clk_run)
    else $error("clock halted outside stop");

  a_tick_pseudo_run: assert property (
    (stop_mode && st.clks[`CCS_BIT_PSTOP] && st.clks[`CCS_BIT_TICK_PSR]
      && st.clks[`CCS_BIT_TICK_SEL]) |-> tick_clk_run)
    else $error("tick halted in pseudo stop");

  a_wd_pseudo_run: assert property (
    (stop_mode && st.clks[`CCS_BIT_PSTOP] && st.clks[`CCS_BIT_WD_PSR]
      && watchdog_src == CCS_WD_OSC) |-> watchdog_clk_run)
    else $error("watchdog halted in pseudo stop");

  a_full_stop_halts: assert property (
    (stop_mode && !st.clks[`CCS_BIT_PSTOP]) |-> !tick_clk_run)
    else $error("tick ran in full stop");

  a_read_idle: assert property (
    !rd |=> rdata == 8'h00)
    else $error("read data without read strobe");

  a_low_freeze: assert property (
    (st.wd_once && !special_mode && !st.low_reset_ok && osc_qualified)
      |=> $stable(st.clks[`CCS_BIT_WD_SRC_LOW]))
    else $error("frozen low select changed");

  c_full_stop: cover property (stop_mode && !st.stop_d && !st.clks[`CCS_BIT_PSTOP]);
  c_aclk_gated: cover property (stop_mode && !watchdog_aclk_en);
  c_low_again: cover property (st.wd_once && st.low_reset_ok ##1 !st.low_reset_ok);
  c_osc_loss: cover property (osc_qualified ##1 !osc_qualified);
  c_pseudo_run: cover property (stop_mode && tick_clk_run && watchdog_clk_run);

endmodule

/* File: dv/ccs_ctrl_tb_top.sv */
// self-checking testbench of the clock source select block
`timescale 1ns/1ps
`include "ccs_defines.svh"
module ccs_ctrl_tb_top import ccs_pkg::*;;
  // ==========================================================
  // signals
  logic clk, rst, wr, rd, lock, spec, wcw, oq, stp, at;
  logic sp, lk;
  logic [7:0] addr, wdata, rdata, v, rv, prev;
  logic pll, ors, wre, wce, wae, tfo, tre, tcr, wke;
  ccs_wd_src_e wsrc;
  int err_count, n_tests;
  // stand-in for the oscillator startup wait, in bus cycles
  localparam int OSC_STARTUP_CYC = 16;
  ccs_ctrl DUT (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .write_lock_flag(lock), .special_mode(spec), .watchdog_ctrl_write(wcw),
    .osc_qualified(oq), .stop_mode(stp), .aclk_tick(at), .sys_clk_from_pll(pll),
    .osc_run_in_stop(ors), .watchdog_src(wsrc), .watchdog_restart(wre),
    .watchdog_clk_run(wce), .watchdog_aclk_en(wae), .tick_from_osc(tfo),
    .tick_restart(tre), .tick_clk_run(tcr), .wakeup_aclk_en(wke));
  // ==========================================================
  // helpers
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask
  // expected register after a write, once the watchdog write-once has happened
  function automatic logic [7:0] exp_write(input logic [7:0] old, input logic [7:0] d,
      input logic s, input logic l);
    logic [7:0] m;
    m = s ? 8'hff : 8'hce;
    if (l) m = 8'h00;
    return (old & ~m) | (d & m);
  endfunction
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 0;
    #1;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1; addr <= a;
    @(posedge clk);
    rd <= 0;
    #1 d = rdata;
  endtask
  task automatic pulse_in(input logic aclk, input int n);
    @(posedge clk);
    if (aclk) at <= 1;
    else wcw <= 1;
    repeat (n) @(posedge clk);
    at <= 0;
    wcw <= 0;
    #1;
  endtask
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #(4000 * 25);
    err_count++;
    final_report();
  end
  // ==========================================================
  // tests
  initial begin
    {rst, wr, rd, lock, spec, wcw, stp, at} = 8'h80;
    oq = 1; addr = 0; wdata = 0; err_count = 0; n_tests = 0;
    void'($urandom(32'hc001a108));
    repeat (6) @(posedge clk);
    rst <= 0;
    rd_reg(`CCS_OFF_CLKS, v); chk(v, `CCS_CLKS_RESET);
    rd_reg(8'h05, v); chk(v, 8'h00);
    done("reset");
    lock <= 1; wr_reg(`CCS_OFF_CLKS, 8'h7f);
    rd_reg(`CCS_OFF_CLKS, v); chk(v, `CCS_CLKS_RESET);
    lock <= 0; done("lock");
    wr_reg(`CCS_OFF_CLKS, 8'h13);
    chk(pll, 1'b0);
    chk(wsrc, CCS_WD_ACLK);
    chk(tfo, 1'b1);
    chk(wre, 1'b1);
    chk(tre, 1'b1);
    pulse_in(1'b0, 1);
    wr_reg(`CCS_OFF_CLKS, 8'hee);
    rd_reg(`CCS_OFF_CLKS, v); chk(v, 8'hdf);
    wr_reg(`CCS_OFF_CLKS, 8'h13);
    done("normal");
    @(posedge clk) oq <= 0;
    @(posedge clk) oq <= 1;
    rd_reg(`CCS_OFF_CLKS, v); chk(v, 8'h90);
    rd_reg(`CCS_OFF_STAT, v); chk(v, 8'h07);
    wr_reg(`CCS_OFF_CLKS, 8'h11);
    chk(wre, 1'b0);
    rd_reg(`CCS_OFF_CLKS, v); chk(v, 8'h11);
    stp <= 1; #30;
    rd_reg(`CCS_OFF_CLKS, v); chk(v, 8'h91);
    stp <= 0;
    pulse_in(1'b1, 2);
    repeat (OSC_STARTUP_CYC) @(posedge clk);
    done("osc loss and stop");
    spec <= 1; wr_reg(`CCS_OFF_CLKS, 8'h64);
    chk(ors, 1'b1);
    chk(wre, 1'b1);
    stp <= 1; pulse_in(1'b1, 3);
    chk(wae, 1'b0);
    chk(wke, 1'b1);
    chk(wce, 1'b0);
    chk(tcr, 1'b0);
    stp <= 0; pulse_in(1'b1, 3);
    chk(wae, 1'b1);
    chk(tcr, 1'b1);
    done("stop gating");
    oq <= 0; wr_reg(`CCS_OFF_CLKS, 8'h03);
    rd_reg(`CCS_OFF_CLKS, v); chk(v, 8'h80);
    oq <= 1; done("unqualified write");
    prev = 8'h80;
    repeat (20) begin
      v = 8'($urandom);
      sp = 1'($urandom);
      lk = 2'($urandom) == 2'b00;
      spec <= sp;
      lock <= lk;
      wr_reg(`CCS_OFF_CLKS, v);
      prev = exp_write(prev, v, sp, lk);
      rd_reg(`CCS_OFF_CLKS, rv); chk(rv, prev);
      @(posedge clk);
      #1 chk(rdata, 8'h00);
    end
    done("random writes");
    final_report();
  end
endmodule
